// ### verilog/fsp_host.sv
// Host-side bus controller that drives a parallel flash through its pins.
module fsp_host
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  output logic req_ready,
  input wire fsp_req_s req,
  output logic resp_valid,
  output logic [7:0] resp_data,
  input wire logic supply_ok,
  input wire logic operation_done_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic reset_hv_en,
  output logic a9_hv_en,
  output logic [20:0] flash_addr,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe_n,
  input wire logic [7:0] data_pins_i
);

  // ********************************************************
  // Input synchronisers
  // ********************************************************
  logic [7:0] din_s1_r;
  logic [7:0] din_s2_r;
  logic sup_s1_r;
  logic sup_s2_r;
  logic done_s1_r;
  logic done_s2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
      done_s1_r <= 1'b1;
      done_s2_r <= 1'b1;
    end else if (ce) begin
      din_s1_r <= data_pins_i;
      din_s2_r <= din_s1_r;
      sup_s1_r <= supply_ok;
      sup_s2_r <= sup_s1_r;
      done_s1_r <= operation_done_n;
      done_s2_r <= done_s1_r;
    end
  end

  // ********************************************************
  // Step table
  // ********************************************************
  // Identify reads force bit 6 low and keep the caller's bits 20-18, 1 and 0.
  function automatic fsp_step_s step_of(input fsp_op_e op, input logic [2:0] n,
                                        input logic [20:0] a, input logic [7:0] d);
    fsp_step_s s;
    logic [20:0] ida;
    s = '{is_rd: 1'b0, last: 1'b1, addr: a, data: d};
    ida = a;
    ida[ID_A6_BIT] = 1'b0; // see RL7
    case (op)
      OP_READ: begin
        s.is_rd = 1'b1;
      end
      OP_ID_HV: begin
        s.is_rd = 1'b1; // see RL9
        s.addr = ida; // see RL8
      end
      OP_RESET: begin
        s.data = CMD_RESET;
      end
      OP_PROGRAM, OP_ID_CMD: begin
        s.last = 1'b0;
        if (n == 3'd0) begin
          s.addr = UNLOCK_A1; // see RL18
          s.data = CMD_UNLOCK1;
        end else if (n == 3'd1) begin
          s.addr = UNLOCK_A2;
          s.data = CMD_UNLOCK2;
        end else if (n == 3'd2) begin
          s.addr = UNLOCK_A1;
          s.data = (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_IDENT; // see RL10
        end else if (op == OP_PROGRAM) begin
          s.last = 1'b1;
        end else if (n == 3'd3) begin
          s.is_rd = 1'b1;
          s.addr = ida;
        end else begin
          s.data = CMD_RESET; // see RL21
          s.last = 1'b1;
        end
      end
      default: begin
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction

  // ********************************************************
  // Sequencer
  // ********************************************************
  fsp_state_e state_r;
  fsp_state_e state_nxt;
  fsp_req_s cur_r;
  logic [2:0] step_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [7:0] rdata_r;
  logic rd_phase_r;
  logic wr_phase_r;
  logic hv_r;
  logic a9hv_r;
  logic resp_r;
  fsp_step_s stp;
  wire logic take = req_valid && req_ready;
  wire logic cnt_done = (cnt_r == '0);
  wire logic is_unprot = (req.op == OP_UNPROT_ON) || (req.op == OP_UNPROT_OFF);

  assign stp = step_of(cur_r.op, step_r, cur_r.addr, cur_r.data);
  // Nothing is started until the supply has been seen good through the synchroniser.
  assign req_ready = (state_r == S_IDLE) && sup_s2_r; // see RL19

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      S_IDLE: begin
        if (take && (is_unprot || req.op == OP_ID_HV)) begin
          state_nxt = S_HOLD;
          cnt_nxt = CNT_W'(C_VID);
        end else if (take) begin
          state_nxt = S_SETUP;
          cnt_nxt = CNT_W'(C_SETUP);
        end
      end
      S_HOLD: begin
        if (cnt_done && cur_r.op == OP_ID_HV) begin
          state_nxt = S_SETUP;
          cnt_nxt = CNT_W'(C_SETUP);
        end else if (cnt_done) begin
          state_nxt = S_IDLE;
        end
      end
      S_SETUP: begin
        if (cnt_done) begin
          state_nxt = S_PULSE;
          cnt_nxt = stp.is_rd ? CNT_W'(C_ACC) : CNT_W'(C_WP); // see RL14
        end
      end
      S_PULSE: begin
        if (cnt_done) begin
          state_nxt = S_GAP;
          cnt_nxt = CNT_W'(C_GAP);
        end
      end
      S_GAP: begin
        if (cnt_done && !stp.last) begin
          state_nxt = S_SETUP;
          cnt_nxt = CNT_W'(C_SETUP);
        end else if (cnt_done && cur_r.op == OP_PROGRAM) begin
          state_nxt = S_WAIT;
          cnt_nxt = CNT_W'(C_BUSY);
        end else if (cnt_done) begin
          state_nxt = S_IDLE;
        end
      end
      S_WAIT: begin
        if (cnt_done && done_s2_r) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  wire logic finish = (state_r != S_IDLE) && (state_nxt == S_IDLE);
  wire logic pulse_end = (state_r == S_PULSE) && cnt_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      cur_r <= '0;
      step_r <= 3'd0;
      rdata_r <= RDATA_RST;
      resp_r <= 1'b0;
      hv_r <= 1'b0;
      a9hv_r <= 1'b0;
      rd_phase_r <= 1'b0;
      wr_phase_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      resp_r <= finish;
      if (take) begin
        cur_r <= req;
        step_r <= 3'd0;
      end
      if (take && req.op == OP_UNPROT_ON) begin
        hv_r <= 1'b1; // see RL11
      end else if (take && req.op == OP_UNPROT_OFF) begin
        hv_r <= 1'b0; // see RL12
      end
      if (take) begin
        a9hv_r <= (req.op == OP_ID_HV); // see RL7
      end else if (finish) begin
        a9hv_r <= 1'b0;
      end
      if (pulse_end && stp.is_rd) begin
        rdata_r <= din_s2_r; // see RL9
      end
      if ((state_r == S_GAP) && cnt_done && !stp.last) begin
        step_r <= step_r + 3'd1;
      end
      rd_phase_r <= (state_nxt == S_PULSE) && stp.is_rd;
      // Write enable and chip select fall together and rise together, so the flash
      // sees one edge pair for address and data capture.
      wr_phase_r <= (state_nxt == S_PULSE) && !stp.is_rd; // see RL20
    end
  end

  // ********************************************************
  // Pin drive
  // ********************************************************
  logic [20:0] addr_r;
  logic [7:0] dout_r;
  logic doe_n_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= '0;
      dout_r <= 8'h00;
      doe_n_r <= 1'b1;
    end else if (ce) begin
      addr_r <= (state_nxt == S_IDLE) ? addr_r : stp.addr;
      dout_r <= stp.data;
      // Data is driven across setup, pulse and gap of a write only, never while output
      // enable is low, so host and flash never fight on the data pins.
      doe_n_r <= !((state_nxt == S_SETUP || state_nxt == S_PULSE || state_nxt == S_GAP)
                   && !stp.is_rd && !(state_r == S_IDLE)); // see RL1
    end
  end

  // Chip select, output and write enable stay high through reset and while the supply
  // is not yet good, so no write can form during power-up.
  assign flash_we_n = !(wr_phase_r && sup_s2_r); // see RL15 RL16
  assign flash_oe_n = !(rd_phase_r && sup_s2_r) || wr_phase_r; // see RL15
  assign flash_ce_n = !((rd_phase_r || wr_phase_r) && sup_s2_r);
  assign flash_reset_n = sup_s2_r; // see RL13 RL17
  assign reset_hv_en = hv_r && sup_s2_r;
  assign a9_hv_en = a9hv_r;
  assign flash_addr = addr_r;
  assign data_pins_o = dout_r;
  assign data_pins_oe_n = doe_n_r || rd_phase_r;
  assign resp_valid = resp_r;
  assign resp_data = rdata_r;

endmodule

// ### verilog/fsp_pkg.sv
// Constants, types and step encodings for the flash sector-protect host controller.
// Behaviour
// RL1 - With output enable high the flash floats its data pins; host drives only then.
// RL2 - Thirty-two 64 Kbyte sectors, index taken from address bits 20 to 16.
// RL3 - Eight protection groups of four sectors, index from address bits 20 to 18.
// RL4 - Flash refuses program and erase inside a protected group.
// RL5 - Unprotecting a group makes program and erase possible again.
// RL6 - Flash is delivered with every group unprotected.
// RL7 - High-voltage identify: bit nine at high voltage, bits 6 and 1 low, bit 0 picks code.
// RL8 - Protection check: group on bits 20-18, bit 1 high, bit 0 low; one or 00h.
// RL9 - Identification values are read with an ordinary read cycle.
// RL10 - Flash also gives identification through an unlock command sequence.
// RL11 - High voltage on the reset pin enters temporary unprotect.
// RL12 - Removing that voltage restores all previous protection.
// RL13 - Below the lockout supply threshold the flash ignores writes and resets.
// RL14 - Control pulses under about 5 ns start no write cycle.
// RL15 - Write only with chip select and write enable low and output enable high.
// RL16 - Write enable low during power-up must not yield a command.
// RL17 - Flash resets itself to array read at power-up.
// RL18 - Program and erase only after unlock cycles issued by the host.
// RL19 - Above the threshold the host holds controls where no stray write forms.
// RL20 - Flash takes address on the later falling and data on the earlier rising edge.
// RL21 - A wrong command sequence returns the flash to array read.
// RL22 - Flash keeps eight protection flags and checks the group before program or erase.
package fsp_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_MHZ = 100;
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS = 40;
  localparam int T_ACC_NS = 90;
  localparam int T_GAP_NS = 30;
  localparam int T_VID_NS = 4000;
  localparam int T_BUSY_NS = 100;
  localparam int SYNC_LAT = 2;
  localparam int C_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int C_WP = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int C_ACC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_LAT;
  localparam int C_GAP = (T_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int C_VID = (T_VID_NS * CLK_MHZ + 999) / 1000;
  localparam int C_BUSY = (T_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 10;

  // ********************************************************
  // Addresses and command bytes
  // ********************************************************
  localparam int ADDR_W = 21;
  localparam int SECTOR_LSB = 16;
  localparam int GROUP_LSB = 18;
  localparam int ID_SEL_BIT = 0;
  localparam int ID_PROT_BIT = 1;
  localparam int ID_A6_BIT = 6;
  localparam logic [20:0] UNLOCK_A1 = 21'h00_0555;
  localparam logic [20:0] UNLOCK_A2 = 21'h00_02AA;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_ID_HV = 3'h3,
    OP_ID_CMD = 3'h4,
    OP_RESET = 3'h5,
    OP_UNPROT_ON = 3'h6,
    OP_UNPROT_OFF = 3'h7
  } fsp_op_e;

  typedef struct packed {
    fsp_op_e op;
    logic [20:0] addr;
    logic [7:0] data;
  } fsp_req_s;

  typedef struct packed {
    logic is_rd;
    logic last;
    logic [20:0] addr;
    logic [7:0] data;
  } fsp_step_s;

  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_SETUP = 6'b00_0010,
    S_PULSE = 6'b00_0100,
    S_GAP = 6'b00_1000,
    S_WAIT = 6'b01_0000,
    S_HOLD = 6'b10_0000
  } fsp_state_e;

endpackage

// ### sim/fsp_host_sva.sv
// Pin-level assertion checker for the flash host controller.
module fsp_host_sva
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic a9_hv_en,
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] data_pins_o,
  input wire logic data_pins_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Bus checks
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_wr_gate; !flash_we_n |-> flash_oe_n && !flash_ce_n; endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write strobe without select");
  property p_lock; !flash_reset_n |-> flash_we_n && flash_ce_n; endproperty
  a_lock: assert property (p_lock) else $error("controls active in lockout");
  property p_rd_bus; !flash_oe_n |-> data_pins_oe_n && flash_we_n; endproperty
  a_rd_bus: assert property (p_rd_bus) else $error("host drives data in read");
  property p_id_a6; a9_hv_en && !flash_oe_n |-> !flash_addr[ID_A6_BIT]; endproperty
  a_id_a6: assert property (p_id_a6) else $error("bit six high in identify");
  property p_wp_len; $fell(flash_we_n) |=> !flash_we_n [*2]; endproperty
  a_wp_len: assert property (p_wp_len) else $error("write pulse too short");
  property p_addr_hold; !flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
  property p_data_hold; !flash_we_n |=> flash_we_n || $stable(data_pins_o); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved in write");
  property p_unlock;
    $fell(flash_we_n) && data_pins_o == CMD_PROGRAM |-> flash_addr == UNLOCK_A1;
  endproperty
  a_unlock: assert property (p_unlock) else $error("program byte off unlock address");
endmodule

bind fsp_host fsp_host_sva u_sva (.clk, .rst, .flash_ce_n, .flash_oe_n, .flash_we_n,
  .flash_reset_n, .a9_hv_en, .flash_addr, .data_pins_o, .data_pins_oe_n);

// ### sim/fsp_flash_model.sv
// Behavioural model of the parallel flash behind the host controller.
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value.
  parameter logic [7:0] PART_ID = 8'hC3 // Arbitrary value.
)
(
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic reset_hv,
  input wire logic a9_hv,
  input wire logic [20:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic [7:0] prot_in,
  output logic [7:0] dq_out,
  output logic done_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [20:0]];
  logic [1:0] step = 2'd0;
  logic id_mode = 1'b0;
  logic act = 1'b0;
  logic busy = 1'b0;
  logic [20:0] la;
  time t0;

  function automatic logic [7:0] rdv(input logic [20:0] a);
    if ((a9_hv || id_mode) && !a[ID_A6_BIT]) begin
      if (a[ID_PROT_BIT]) begin
        return {7'h00, prot_in[a[20:18]]};
      end
      return a[ID_SEL_BIT] ? PART_ID : MAKER_ID;
    end
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // A released bus shows the inverted byte so a stale value never passes.
  assign dq_out = (ce_n || oe_n || !reset_n) ? ~rdv(addr) : rdv(addr);

  assign done_n = !busy;

  task automatic take(input logic [20:0] a, input logic [7:0] d);
    logic ok;
    ok = 1'b0;
    case (step)
      2'd0: ok = (a == UNLOCK_A1 && d == CMD_UNLOCK1);
      2'd1: ok = (a == UNLOCK_A2 && d == CMD_UNLOCK2);
      2'd2: begin
        id_mode = (a == UNLOCK_A1 && d == CMD_IDENT);
        ok = (a == UNLOCK_A1 && d == CMD_PROGRAM);
      end
      default: begin
        if (!prot_in[a[20:18]] || reset_hv) begin
          mem[a] = rdv(a) & d;
        end
        fork
          begin
            busy = 1'b1;
            #100;
            busy = 1'b0;
          end
        join_none
      end
    endcase
    if (d == CMD_RESET) begin
      id_mode = 1'b0;
    end
    step = ok ? step + 2'd1 : 2'd0;
  endtask

  // Reset is handled in the same process so that the command state has one writer.
  always @(ce_n or we_n or oe_n or reset_n) begin
    if (!reset_n) begin
      step = 2'd0;
      id_mode = 1'b0;
      act = 1'b0;
    end else if (!ce_n && !we_n && oe_n && !act) begin
      act = 1'b1;
      t0 = $time;
      la = addr;
    end else if (act && (ce_n || we_n || !oe_n)) begin
      act = 1'b0;
      if ($time - t0 >= 5) begin
        take(la, dq_in);
      end
    end
  end
endmodule

// ### sim/flash_sector_protect_autoselect_tb.sv
// Self-checking bench for the flash host controller.
module flash_sector_protect_autoselect_tb
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER_ID = 8'h3C; // Arbitrary value.
  localparam logic [7:0] PART_ID = 8'hC3; // Arbitrary value.
  typedef struct packed {fsp_op_e op; logic [20:0] a; logic [7:0] d; logic [7:0] p; logic [7:0] e;} fsp_row_s;
  logic clk, rst, ce, req_valid, req_ready, resp_valid, supply_ok, operation_done_n;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, reset_hv_en, a9_hv_en;
  logic data_pins_oe_n;
  logic [20:0] flash_addr;
  logic [7:0] resp_data, data_pins_o, data_pins_i, fl_dq, prot, got;
  fsp_req_s req;
  int err_count = 0;
  int num_checks = 0;
  fsp_row_s rows [21] = '{
    '{OP_PROGRAM, 21'h01_2345, 8'h5A, 8'h00, 8'h00},
    '{OP_READ, 21'h01_2345, 8'h00, 8'h00, 8'h5A},
    '{OP_ID_HV, 21'h00_0000, 8'h00, 8'h00, MAKER_ID},
    '{OP_ID_HV, 21'h00_0001, 8'h00, 8'h00, PART_ID},
    '{OP_ID_HV, 21'h00_0041, 8'h00, 8'h00, PART_ID},
    '{OP_ID_HV, 21'h1C_0002, 8'h00, 8'h00, 8'h00},
    '{OP_ID_CMD, 21'h00_0000, 8'h00, 8'h00, MAKER_ID},
    '{OP_ID_CMD, 21'h00_0001, 8'h00, 8'h00, PART_ID},
    '{OP_PROGRAM, 21'h1F_0000, 8'h00, 8'h80, 8'h00},
    '{OP_READ, 21'h1F_0000, 8'h00, 8'h80, 8'hFF},
    '{OP_ID_HV, 21'h1C_0002, 8'h00, 8'h80, 8'h01},
    '{OP_ID_HV, 21'h18_0002, 8'h00, 8'h80, 8'h00},
    '{OP_UNPROT_ON, 21'h00_0000, 8'h00, 8'h80, 8'h00},
    '{OP_PROGRAM, 21'h1F_0000, 8'h0F, 8'h80, 8'h00},
    '{OP_UNPROT_OFF, 21'h00_0000, 8'h00, 8'h80, 8'h00},
    '{OP_READ, 21'h1F_0000, 8'h00, 8'h80, 8'h0F},
    '{OP_ID_HV, 21'h1C_0002, 8'h00, 8'h80, 8'h01},
    '{OP_WRITE, 21'h00_0555, 8'hAA, 8'h00, 8'h00},
    '{OP_RESET, 21'h00_0000, 8'h00, 8'h00, 8'h00},
    '{OP_PROGRAM, 21'h1C_0000, 8'h33, 8'h00, 8'h00},
    '{OP_READ, 21'h1C_0000, 8'h00, 8'h00, 8'h33}};

  assign data_pins_i = data_pins_oe_n ? fl_dq : data_pins_o;

  fsp_host dut (.clk, .rst, .ce, .req_valid, .req_ready, .req, .resp_valid, .resp_data,
    .supply_ok, .operation_done_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
    .reset_hv_en, .a9_hv_en, .flash_addr, .data_pins_o, .data_pins_oe_n, .data_pins_i);

  fsp_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) flash (.ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n), .reset_hv(reset_hv_en),
    .a9_hv(a9_hv_en), .addr(flash_addr), .dq_in(data_pins_i), .prot_in(prot),
    .dq_out(fl_dq), .done_n(operation_done_n));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic run(input fsp_op_e op, input logic [20:0] a, input logic [7:0] d);
    int n;
    logic taken;
    req <= '{op: op, addr: a, data: d};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      taken = (req_ready === 1'b1);
      @(posedge clk);
      n++;
    end while (!taken && n < 100);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 2000);
    chk("handshake", 8'h01, {7'h00, taken && resp_valid === 1'b1});
    got = resp_data;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req = '0;
    supply_ok = 1'b1;
    prot = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      prot <= rows[i].p;
      run(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op inside {OP_READ, OP_ID_HV, OP_ID_CMD}) begin
        chk("resp_data", rows[i].e, got);
      end
    end
    chk("reset_hv_en", 8'h00, {7'h00, reset_hv_en});
    chk("a9_hv_en", 8'h00, {7'h00, a9_hv_en});
    // With the clock enable low the supply synchroniser must not move.
    ce <= 1'b0;
    supply_ok <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("flash_reset_n", 8'h01, {7'h00, flash_reset_n});
    @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("req_ready", 8'h00, {7'h00, req_ready});
    chk("flash_reset_n", 8'h00, {7'h00, flash_reset_n});
    @(posedge clk);
    supply_ok <= 1'b1;
    repeat (4) @(posedge clk);
    run(OP_READ, 21'h01_2345, 8'h00);
    chk("resp_data", 8'h5A, got);
    // A reset between runs clears the answer register and parks the controls.
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("resp_data", RDATA_RST, resp_data);
    chk("flash_ce_n", 8'h01, {7'h00, flash_ce_n});
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    run(OP_ID_CMD, 21'h00_0001, 8'h00);
    chk("resp_data", PART_ID, got);
    finish_test();
  end
endmodule
